// ### core/gdm_top.sv
// Top of the gate driver mode control block with its AHB-Lite register slave
//
// Added by the designer: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
module gdm_top (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Control pins
  input wire logic high_side_reset_n_in,
  input wire logic low_side_reset_n_in,
  input wire logic enable_in,
  input wire logic [5:0] phase_pwm_input_in,
  input wire logic [5:0] desat_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Gates and flags
  output logic [5:0] gate_out,
  output logic [5:0] fault_flag_n_out,
  output logic [5:0] ready_out,
  output logic [5:0] indicator_out,
  // Status pins
  output logic status_u_high_out,
  output logic status_v_high_out,
  output logic status_w_high_out,
  output logic status_u_low_out,
  output logic status_v_low_out,
  output logic status_w_low_out,
  output logic status_low_side_all_out
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [gdm_pkg::SYNC_W-1:0] sync1_reg;
  logic [gdm_pkg::SYNC_W-1:0] sync2_reg;
  logic [1:0] rst_prev_reg;
  wire [gdm_pkg::SYNC_W-1:0] pins = {desat_in, phase_pwm_input_in, enable_in,
                      low_side_reset_n_in, high_side_reset_n_in};
  wire hs_rst_s = sync2_reg[0];
  wire ls_rst_s = sync2_reg[1];
  wire en_s = sync2_reg[2];
  wire [5:0] pwm_s = sync2_reg[8:3];
  wire [5:0] desat_s = sync2_reg[14:9];
  // Edge only; the level need not be held afterwards
  wire hs_edge = hs_rst_s & ~rst_prev_reg[0];
  wire ls_edge = ls_rst_s & ~rst_prev_reg[1];

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_reg <= 15'h0000;
      sync2_reg <= 15'h0000;
      rst_prev_reg <= 2'h0;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      rst_prev_reg <= {ls_rst_s, hs_rst_s};
    end
  end

  // ----------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------
  logic gate_allow_reg;
  logic wr_pend_reg;
  logic [3:0] wr_addr_reg;
  logic [31:0] rdata_reg;
  logic low_all_reg;
  gdm_pkg::gdm_mode_t mode_w [6];
  logic [5:0] status_w;

  wire take = hsel_in & hready_in & htrans_in[1];
  wire [3:0] ofs = haddr_in[3:0];
  wire hit_ctrl = (haddr_in[31:4] == 28'h0000000) &&
                  (ofs == gdm_pkg::CTRL_OFS);
  wire hit_stat = (haddr_in[31:4] == 28'h0000000) &&
                  (ofs == gdm_pkg::STATUS_OFS);
  wire hit_mode = (haddr_in[31:4] == 28'h0000000) &&
                  (ofs == gdm_pkg::MODE_OFS);
  wire [31:0] stat_word = {7'h00, low_all_reg, 2'h0, gate_out,
                           2'h0, ready_out, 2'h0, fault_flag_n_out};
  wire [31:0] mode_word = {8'h00, mode_w[5], mode_w[4], mode_w[3],
                           mode_w[2], mode_w[1], mode_w[0]};
  // Unmapped addresses read zero and ignore writes
  wire [31:0] rd_next = hit_ctrl ? {31'h0, gate_allow_reg} :
                        hit_stat ? stat_word :
                        hit_mode ? mode_word : 32'h00000000;
  wire wr_ctrl = wr_pend_reg && (wr_addr_reg == gdm_pkg::CTRL_OFS);

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 4'h0;
      rdata_reg <= 32'h00000000;
      gate_allow_reg <= gdm_pkg::CTRL_GATE_ALLOW_RST;
    end else begin
      wr_pend_reg <= take & hwrite_in & hit_ctrl;
      wr_addr_reg <= ofs;
      if (take && !hwrite_in) begin
        rdata_reg <= rd_next;
      end
      if (wr_ctrl) begin
        gate_allow_reg <= hwdata_in[gdm_pkg::CTRL_GATE_ALLOW_BIT];
      end
    end
  end

  assign hrdata_out = rdata_reg;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;

  // ----------------------------------------------------------------
  // Channels: 0..2 high side U V W, 3..5 low side U V W
  // ----------------------------------------------------------------
  for (genvar i = 0; i < gdm_pkg::NUM_CH; i++) begin : g_ch
    wire edge_i = (i < gdm_pkg::NUM_HIGH) ? hs_edge : ls_edge;
    gdm_channel u_ch (
      .mclk_in(mclk_in),
      .rst_in(rst_in),
      .reset_edge_in(edge_i),
      .enable_in(en_s),
      .pwm_in(pwm_s[i]),
      .desat_in(desat_s[i]),
      .gate_allow_in(gate_allow_reg),
      .mode_out(mode_w[i]),
      .gate_out(gate_out[i]),
      .fault_flag_n_out(fault_flag_n_out[i]),
      .ready_out(ready_out[i]),
      .status_out(status_w[i])
    );
  end

  // Summary built from modes so it lines up with the channel status flops
  wire low_all_next = (mode_w[3] inside {gdm_pkg::GDM_READY,
                                         gdm_pkg::GDM_NORMAL}) &&
                      (mode_w[4] inside {gdm_pkg::GDM_READY,
                                         gdm_pkg::GDM_NORMAL}) &&
                      (mode_w[5] inside {gdm_pkg::GDM_READY,
                                         gdm_pkg::GDM_NORMAL});

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      low_all_reg <= 1'b0;
    end else begin
      low_all_reg <= low_all_next;
    end
  end

  assign indicator_out = status_w;
  assign status_u_high_out = status_w[0];
  assign status_v_high_out = status_w[1];
  assign status_w_high_out = status_w[2];
  assign status_u_low_out = status_w[3];
  assign status_v_low_out = status_w[4];
  assign status_w_low_out = status_w[5];
  assign status_low_side_all_out = low_all_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  for (genvar k = 0; k < gdm_pkg::NUM_CH; k++) begin : g_chk
    wire e_k = (k < gdm_pkg::NUM_HIGH) ? hs_edge : ls_edge;

    property p_reset_to_ready;
      (mode_w[k] == gdm_pkg::GDM_RESET) && e_k
        |=> (mode_w[k] == gdm_pkg::GDM_READY) ##1 ready_out[k];
    endproperty
    a_reset_to_ready: assert property (p_reset_to_ready)
      else $error("reset edge did not give Ready");

    property p_side_reset;
      (mode_w[k] == gdm_pkg::GDM_RESET) && !e_k
        |=> (mode_w[k] == gdm_pkg::GDM_RESET);
    endproperty
    a_side_reset: assert property (p_side_reset)
      else $error("channel left reset without its side edge");

    property p_enable_normal;
      (mode_w[k] == gdm_pkg::GDM_READY) && en_s
        |=> (mode_w[k] == gdm_pkg::GDM_NORMAL);
    endproperty
    a_enable_normal: assert property (p_enable_normal)
      else $error("enable did not give Normal");

    property p_gate_follows;
      ##1 gate_out[k] == $past((mode_w[k] == gdm_pkg::GDM_NORMAL)
                               && pwm_s[k] && gate_allow_reg);
    endproperty
    a_gate_follows: assert property (p_gate_follows)
      else $error("gate does not follow pwm");

    property p_desat_error;
      (mode_w[k] == gdm_pkg::GDM_NORMAL) && desat_s[k]
        |=> (mode_w[k] == gdm_pkg::GDM_ERROR) ##1 !gate_out[k];
    endproperty
    a_desat_error: assert property (p_desat_error)
      else $error("desat did not stop the gate");

    property p_error_clear;
      (mode_w[k] == gdm_pkg::GDM_ERROR) && e_k
        |=> (mode_w[k] == gdm_pkg::GDM_NORMAL) ##1 fault_flag_n_out[k];
    endproperty
    a_error_clear: assert property (p_error_clear)
      else $error("reset edge did not clear error");

    property p_status_and;
      ##1 status_w[k] == $past((mode_w[k] != gdm_pkg::GDM_ERROR) &&
                               (mode_w[k] != gdm_pkg::GDM_RESET));
    endproperty
    a_status_and: assert property (p_status_and)
      else $error("status is not fault and ready");

    property p_gate_off;
      (mode_w[k] inside {gdm_pkg::GDM_READY, gdm_pkg::GDM_ERROR})
        |=> !gate_out[k];
    endproperty
    a_gate_off: assert property (p_gate_off)
      else $error("gate on outside Normal");

    property p_fault_flag;
      (mode_w[k] == gdm_pkg::GDM_ERROR) |=> !fault_flag_n_out[k]
        && !indicator_out[k];
    endproperty
    a_fault_flag: assert property (p_fault_flag)
      else $error("fault flag not low in Error");
  end

  property p_low_all;
    status_low_side_all_out == (status_w[3] & status_w[4] & status_w[5]);
  endproperty
  a_low_all: assert property (p_low_all)
    else $error("low side summary wrong");

  c_ready: cover property (hs_edge ##[1:20]
                           mode_w[0] == gdm_pkg::GDM_READY);
  c_normal_pwm: cover property (mode_w[3] == gdm_pkg::GDM_NORMAL
                                ##1 gate_out[3]);
  c_error_clear: cover property (mode_w[5] == gdm_pkg::GDM_ERROR
                                 ##[1:50] mode_w[5] == gdm_pkg::GDM_NORMAL);

endmodule

// ### pkg/gdm_pkg.sv
// Package of constants and types for the gate driver mode control block
// Function
// - Rising edge on either reset input moves that side's channels from Reset into Ready mode.
// - Enable high while in Ready moves the driver to Normal mode.
// - In Normal mode each gate output follows its phase PWM input; the code also holds all gates off while gate_allow_reg (CTRL bit 0) is 0.
// - Desaturation in Normal turns that channel's gate off, enters Error, suppresses its pulses.
// - Reset rising edge while in Error clears it and returns to Normal.
// - Each channel status output is fault flag AND ready flag.
// - Low-side summary status is the AND of three low-side statuses.
// - Channel indicator lit only when fault and ready flags are both 1.
// - High-side reset drives the three high channels, low-side the low.
// - One enable input acts on all six channels together.
package gdm_pkg;

  // ----------------------------------------------------------------
  // Channel layout
  // ----------------------------------------------------------------
  localparam int NUM_CH = 6;
  localparam int NUM_HIGH = 3;
  localparam int SYNC_W = 15;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] MODE_OFS = 4'h8;
  localparam int CTRL_GATE_ALLOW_BIT = 0;
  localparam logic CTRL_GATE_ALLOW_RST = 1'b1;
  localparam int STATUS_FAULT_POS = 0;
  localparam int STATUS_READY_POS = 8;
  localparam int STATUS_GATE_POS = 16;
  localparam int STATUS_LOW_ALL_POS = 24;

  // ----------------------------------------------------------------
  // Operating modes, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    GDM_RESET  = 4'h1,
    GDM_READY  = 4'h2,
    GDM_NORMAL = 4'h4,
    GDM_ERROR  = 4'h8
  } gdm_mode_t;

endpackage

// ### core/gdm_channel.sv
// One driver channel: operating mode machine, gate and flag outputs
`timescale 1ns/10ps
module gdm_channel (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Synchronised controls
  input wire logic reset_edge_in,
  input wire logic enable_in,
  input wire logic pwm_in,
  input wire logic desat_in,
  input wire logic gate_allow_in,
  // Outputs
  output gdm_pkg::gdm_mode_t mode_out,
  output logic gate_out,
  output logic fault_flag_n_out,
  output logic ready_out,
  output logic status_out
);

  gdm_pkg::gdm_mode_t mode_reg;
  gdm_pkg::gdm_mode_t mode_next;
  logic gate_reg;
  logic fault_reg;
  logic ready_reg;
  logic status_reg;

  wire in_normal = (mode_reg == gdm_pkg::GDM_NORMAL);
  wire in_error = (mode_reg == gdm_pkg::GDM_ERROR);
  wire in_reset = (mode_reg == gdm_pkg::GDM_RESET);
  // Gate only in Normal; Ready and Error force it off
  wire gate_next = in_normal & pwm_in & gate_allow_in;
  wire fault_next = ~in_error;
  wire ready_next = ~in_reset;
  wire status_next = fault_next & ready_next;

  // ----------------------------------------------------------------
  // Mode machine
  // ----------------------------------------------------------------
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      gdm_pkg::GDM_RESET: begin
        if (reset_edge_in) begin
          mode_next = gdm_pkg::GDM_READY;
        end
      end
      gdm_pkg::GDM_READY: begin
        if (enable_in) begin
          mode_next = gdm_pkg::GDM_NORMAL;
        end
      end
      gdm_pkg::GDM_NORMAL: begin
        // Desat wins over a dropped enable: the fault must be latched
        if (desat_in) begin
          mode_next = gdm_pkg::GDM_ERROR;
        end else if (!enable_in) begin
          mode_next = gdm_pkg::GDM_READY;
        end
      end
      gdm_pkg::GDM_ERROR: begin
        if (reset_edge_in) begin
          mode_next = gdm_pkg::GDM_NORMAL;
        end
      end
      default: begin
        mode_next = gdm_pkg::GDM_RESET;
      end
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_reg <= gdm_pkg::GDM_RESET;
      gate_reg <= 1'b0;
      fault_reg <= 1'b1;
      ready_reg <= 1'b0;
      status_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      gate_reg <= gate_next;
      fault_reg <= fault_next;
      ready_reg <= ready_next;
      status_reg <= status_next;
    end
  end

  assign mode_out = mode_reg;
  assign gate_out = gate_reg;
  assign fault_flag_n_out = fault_reg;
  assign ready_out = ready_reg;
  assign status_out = status_reg;

endmodule

// ### test/gdm_pin_model.sv
// Controller model that drives the reset, enable, PWM and desat pins
`timescale 1ns/10ps
module gdm_pin_model (
  // Clock
  input wire logic mclk_in,
  // Pins towards the driver
  output logic high_side_reset_n_out,
  output logic low_side_reset_n_out,
  output logic enable_out,
  output logic [5:0] phase_pwm_input_out,
  output logic [5:0] desat_out
);
  // ----------------------------------------------------------------
  // Pin sequences
  // ----------------------------------------------------------------
  initial begin
    high_side_reset_n_out = 1'b0;
    low_side_reset_n_out = 1'b0;
    enable_out = 1'b0;
    phase_pwm_input_out = 6'h00;
    desat_out = 6'h00;
  end

  // Level held past the two-flop sync, then dropped so the next edge is new
  task automatic side_reset(input logic hs,
                            input logic ls);
    @(posedge mclk_in);
    high_side_reset_n_out <= hs;
    low_side_reset_n_out <= ls;
    repeat (4) @(posedge mclk_in);
    high_side_reset_n_out <= 1'b0;
    low_side_reset_n_out <= 1'b0;
    repeat (4) @(posedge mclk_in);
  endtask

  task automatic drive(input logic en, input logic [5:0] pwm,
                       input logic [5:0] ds);
    @(posedge mclk_in);
    enable_out <= en;
    phase_pwm_input_out <= pwm;
    desat_out <= ds;
  endtask
endmodule

// ### test/tb.sv
// Self-checking bench for the gate driver mode control block
`timescale 1ns/10ps
module tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic mclk, rst, hsel, hwrite;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic hready, hresp, hsr_n, lsr_n, en_pin, st_all;
  logic [5:0] pwm_pin, ds_pin, gate, flt_n, rdy, ind;
  logic [5:0] st;
  int errors, n_compared, md[6], k;
  logic en, gallow;
  logic [5:0] pwm, ds;

  gdm_pin_model pins (.mclk_in(mclk), .high_side_reset_n_out(hsr_n),
    .low_side_reset_n_out(lsr_n), .enable_out(en_pin),
    .phase_pwm_input_out(pwm_pin), .desat_out(ds_pin));

  gdm_top dut_u (.mclk_in(mclk), .rst_in(rst),
    .high_side_reset_n_in(hsr_n), .low_side_reset_n_in(lsr_n),
    .enable_in(en_pin), .phase_pwm_input_in(pwm_pin), .desat_in(ds_pin),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp), .gate_out(gate), .fault_flag_n_out(flt_n),
    .ready_out(rdy), .indicator_out(ind),
    .status_u_high_out(st[0]), .status_v_high_out(st[1]),
    .status_w_high_out(st[2]), .status_u_low_out(st[3]),
    .status_v_low_out(st[4]), .status_w_low_out(st[5]),
    .status_low_side_all_out(st_all));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    if (errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Single word transfer; the bench timeout bounds both waits
  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] r);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'b010;
    do @(posedge mclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge mclk); while (hready !== 1'b1);
    r = hrdata;
  endtask

  // Mode model: 0 Reset, 1 Ready, 2 Normal, 3 Error
  task automatic step_modes;
    for (int i = 0; i < 6; i++) begin
      if (md[i] == 1 && en) md[i] = 2;
      else if (md[i] == 2 && ds[i]) md[i] = 3;
      else if (md[i] == 2 && !en) md[i] = 1;
    end
  endtask

  task automatic compare_all;
    logic [5:0] g, f, r;
    logic [31:0] mw, sw;
    g = 6'h00;
    mw = 32'h0;
    for (int i = 0; i < 6; i++) begin
      g[i] = (md[i] == 2) && pwm[i] && gallow;
      f[i] = md[i] != 3;
      r[i] = md[i] != 0;
      mw[4*i +: 4] = 4'h1 << md[i];
    end
    sw = {7'h0, &(f[5:3] & r[5:3]), 2'h0, g, 2'h0, r, 2'h0, f};
    @(negedge mclk);
    chk("gate", 32'(g), 32'(gate));
    chk("fault_n", 32'(f), 32'(flt_n));
    chk("ready", 32'(r), 32'(rdy));
    chk("indicator", 32'(f & r), 32'(ind));
    chk("status", 32'(f & r), 32'(st));
    chk("low_all", 32'(&(f[5:3] & r[5:3])), 32'(st_all));
    ahb(1'b0, 32'(gdm_pkg::MODE_OFS), 32'h0, rd);
    chk("mode", mw, rd);
    ahb(1'b0, 32'(gdm_pkg::STATUS_OFS), 32'h0, rd);
    chk("status_reg", sw, rd);
    chk("hresp", 32'h0, 32'(hresp));
  endtask

  task automatic pin_set(input logic e, input logic [5:0] p,
                         input logic [5:0] d);
    en = e;
    pwm = p;
    ds = d;
    pins.drive(e, p, d);
    step_modes();
    repeat (6) @(posedge mclk);
    compare_all();
  endtask

  task automatic side(input logic hs, input logic ls);
    pins.side_reset(hs, ls);
    for (int i = 0; i < 6; i++) begin
      if ((i < 3) ? hs : ls) begin
        if (md[i] == 0) md[i] = 1;
        if (md[i] == 3) md[i] = 2;
      end
    end
    step_modes();
    repeat (4) @(posedge mclk);
    compare_all();
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge mclk);
    errors++;
    end_sim();
  end

  initial begin
    void'($urandom(8));
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    errors = 0;
    n_compared = 0;
    md = '{0, 0, 0, 0, 0, 0};
    {en, pwm, ds} = '0;
    gallow = 1'b1;
    rst = 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    compare_all();
    ahb(1'b0, 32'(gdm_pkg::CTRL_OFS), 32'h0, rd);
    chk("ctrl", 32'h1, rd);
    pin_set(1'b1, 6'h3f, 6'h00);
    pin_set(1'b0, 6'h3f, 6'h00);
    side(1'b1, 1'b0);
    side(1'b0, 1'b1);
    pin_set(1'b1, 6'($urandom), 6'h00);
    repeat (6) pin_set(1'b1, 6'($urandom), 6'h00);
    k = $urandom_range(5, 0);
    pin_set(1'b1, 6'h3f, 6'h01 << k);
    pin_set(1'b1, 6'($urandom), 6'h00);
    side(1'b1, 1'b1);
    ahb(1'b1, 32'(gdm_pkg::CTRL_OFS), 32'h0, rd);
    gallow = 1'b0;
    pin_set(1'b1, 6'h3f, 6'h00);
    ahb(1'b1, 32'(gdm_pkg::CTRL_OFS), 32'h1, rd);
    gallow = 1'b1;
    pin_set(1'b1, 6'h2a, 6'h00);
    ahb(1'b1, 32'h10, 32'hffff_ffff, rd);
    ahb(1'b0, 32'h10, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    pin_set(1'b0, 6'h3f, 6'h00);
    pin_set(1'b0, 6'h3f, 6'h3f);
    @(posedge mclk);
    rst <= 1'b1;
    @(posedge mclk);
    rst <= 1'b0;
    md = '{0, 0, 0, 0, 0, 0};
    compare_all();
    end_sim();
  end
endmodule
